//--- pin_function_select_cfg.svh
// Summary of operation
// - Port D pin 6..0 selector: 0 routes port I/O, 1 routes bus data line.
// - Port D selectors reset to 0, or 1 in ROM-disabled expansion mode.
// - Port E direction register is 16 bits, read/write, bit n for pin n.
// - Direction bit 1 makes the pin an output, 0 an input.
// - Direction applies only to port I/O and timer functions.
// - Port E direction register resets to all zeros.
// - Two 16-bit read/write port E control registers; only the first picks pin functions, for pins 15..12.
// - Pin 15 field: port, timer 4D, DMA acknowledge 1, interrupt out; reset 00.
// - Pin 14 field: port, timer 4C, DMA acknowledge 0, 11 prohibited; reset 00.
// - Pin 13 field: port, timer 4B, manual reset in, 11 prohibited; reset 00.
// - Pin 12 field: port, timer 4A, 11 serial 3 transmit, 10 prohibited.
`ifndef PIN_FUNCTION_SELECT_CFG_SVH
`define PIN_FUNCTION_SELECT_CFG_SVH

`define PD_SEL_OFS 4'h0
`define PE_DIR_OFS 4'h4
`define PE_SEL1_OFS 4'h8
`define PE_SEL2_OFS 4'hC

`define PD_SEL_RST 7'h00
`define PE_DIR_RST 16'h0000
`define PE_SEL_RST 16'h0000

`define PE15_FLD 15
`define PE14_FLD 13
`define PE13_FLD 11
`define PE12_FLD 9
`define PE_MUX_LO 12

`endif

//--- pin_function_select_pkg.sv
package pin_function_select_pkg;

  typedef enum logic [5:0] {
    FN_GPIO = 6'h01,
    FN_TIMER = 6'h02,
    FN_DMA = 6'h04,
    FN_IRQ = 6'h08,
    FN_MANUAL_RESET = 6'h10,
    FN_TXD = 6'h20
  } pin_func_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK = 2'h2
  } bus_state_e;

  typedef struct packed {
    logic [3:0] addr;
    logic wr;
    logic [15:0] wdata;
    logic [1:0] be;
  } bus_req_s;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_s;

endpackage : pin_function_select_pkg

//--- pin_function_select.sv
`timescale 1ns/1ps
`include "pin_function_select_cfg.svh"

module pin_function_select (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_rom_disabled_mode_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [6:0] pd_pin_i,
  output logic [6:0] pd_pin_o,
  output logic [6:0] pd_pin_oe_o,
  input wire logic [6:0] pd_gpio_out_i,
  input wire logic [6:0] pd_gpio_oe_i,
  output logic [6:0] pd_gpio_in_o,
  input wire logic [6:0] bus_data_out_i,
  input wire logic [6:0] bus_data_oe_i,
  output logic [6:0] bus_data_in_o,
  input wire logic [15:0] pe_pin_i,
  output logic [15:0] pe_pin_o,
  output logic [15:0] pe_pin_oe_o,
  input wire logic [15:0] pe_gpio_out_i,
  output logic [15:0] pe_gpio_in_o,
  input wire logic [3:0] timer4_out_i,
  output logic [3:0] timer4_in_o,
  input wire logic [1:0] dma_ack_i,
  input wire logic irq_out_i,
  input wire logic serial3_txd_i,
  output logic manual_reset_in_o
);
  import pin_function_select_pkg::*;

  // Maps a two-bit selector of port E pins 15..12 to its function.
  // Prohibited codes fall back to port I/O.
  function automatic pin_func_e decode_pe_func(
    input logic [1:0] pin,
    input logic [1:0] code
  );
    pin_func_e f;
    f = FN_GPIO;
    if (code == 2'h1) begin
      f = FN_TIMER;
    end else if (code == 2'h2) begin
      unique case (pin)
        2'h3: f = FN_DMA;
        2'h2: f = FN_DMA;
        2'h1: f = FN_MANUAL_RESET;
        default: f = FN_GPIO;
      endcase
    end else if (code == 2'h3) begin
      unique case (pin)
        2'h3: f = FN_IRQ;
        2'h0: f = FN_TXD;
        default: f = FN_GPIO;
      endcase
    end
    return f;
  endfunction : decode_pe_func

  // Merges two byte lanes of a write into a 16-bit register.
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [15:0] wdata,
    input logic [1:0] be
  );
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      r[15:8] = wdata[15:8];
    end
    return r;
  endfunction : merge16

  // Gives a one-hot hit over the four registers for a byte address.
  // Unmapped addresses hit nothing, so reads return 0 and writes are dropped.
  function automatic logic [3:0] reg_hit(
    input logic [3:0] addr
  );
    logic [3:0] h;
    h = 4'h0;
    unique case (addr)
      `PD_SEL_OFS: h = 4'h1;
      `PE_DIR_OFS: h = 4'h2;
      `PE_SEL1_OFS: h = 4'h4;
      `PE_SEL2_OFS: h = 4'h8;
      default: h = 4'h0;
    endcase
    return h;
  endfunction : reg_hit

  bus_state_e bus_state_reg;
  bus_state_e bus_state_next;
  bus_req_s req_reg;
  bus_req_s req_next;
  logic strap_pending_reg;
  logic strap_pending_next;
  logic waitrequest_reg;
  logic waitrequest_next;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;

  // Software-visible registers; port D keeps only bits 6..0 and reads 0 above.
  logic [6:0] pd_sel_reg;
  logic [6:0] pd_sel_next;
  logic [15:0] pe_dir_reg;
  logic [15:0] pe_dir_next;
  logic [15:0] pe_sel1_reg;
  logic [15:0] pe_sel1_next;
  logic [15:0] pe_sel2_reg;
  logic [15:0] pe_sel2_next;

  logic [6:0] pd_out_reg;
  logic [6:0] pd_out_next;
  logic [6:0] pd_oe_reg;
  logic [6:0] pd_oe_next;
  logic [6:0] pd_gin_reg;
  logic [6:0] pd_gin_next;
  logic [6:0] bd_in_reg;
  logic [6:0] bd_in_next;
  logic [15:0] pe_out_reg;
  logic [15:0] pe_out_next;
  logic [15:0] pe_oe_reg;
  logic [15:0] pe_oe_next;
  logic [15:0] pe_gin_reg;
  logic [15:0] pe_gin_next;
  logic [3:0] tmr_in_reg;
  logic [3:0] tmr_in_next;
  logic manual_reset_reg;
  logic manual_reset_next;

  // Two-bit codes of pins 15..12, indexed by pin number minus 12.
  logic [1:0] pe_code [4];

  assign pe_code[3] = pe_sel1_reg[`PE15_FLD -: 2];
  assign pe_code[2] = pe_sel1_reg[`PE14_FLD -: 2];
  assign pe_code[1] = pe_sel1_reg[`PE13_FLD -: 2];
  assign pe_code[0] = pe_sel1_reg[`PE12_FLD -: 2];

  // Bus slave. A request is latched in IDLE and answered one cycle later
  // with waitrequest low; writes commit on that answering edge.
  // The first cycle after reset is spent catching the mode strap, so the
  // bus stalls there rather than race the strap load.
  always_comb begin
    bus_state_next = bus_state_reg;
    req_next = req_reg;
    strap_pending_next = 1'b0;
    waitrequest_next = 1'b1;
    readdata_next = readdata_reg;
    pd_sel_next = pd_sel_reg;
    pe_dir_next = pe_dir_reg;
    pe_sel1_next = pe_sel1_reg;
    pe_sel2_next = pe_sel2_reg;
    if (strap_pending_reg) begin
      pd_sel_next = {7{ext_rom_disabled_mode_i}};
    end
    unique case (bus_state_reg)
      BUS_IDLE: begin
        if (!strap_pending_reg && (avs_read_i || avs_write_i)) begin
          bus_state_next = BUS_ACK;
          waitrequest_next = 1'b0;
          req_next.addr = avs_address_i;
          req_next.wr = avs_write_i;
          req_next.wdata = avs_writedata_i[15:0];
          req_next.be = avs_byteenable_i[1:0];
          unique case (reg_hit(avs_address_i))
            4'h1: readdata_next = {25'h0000000, pd_sel_reg};
            4'h2: readdata_next = {16'h0000, pe_dir_reg};
            4'h4: readdata_next = {16'h0000, pe_sel1_reg};
            4'h8: readdata_next = {16'h0000, pe_sel2_reg};
            default: readdata_next = 32'h00000000;
          endcase
        end
      end
      BUS_ACK: begin
        bus_state_next = BUS_IDLE;
        // Read data drops back to 0 when the answer ends, so no stale word lingers.
        readdata_next = 32'h00000000;
        if (req_reg.wr) begin
          unique case (reg_hit(req_reg.addr))
            4'h1: begin
              // All seven selectors sit in the low byte, so only lane 0 counts.
              if (req_reg.be[0]) begin
                pd_sel_next = req_reg.wdata[6:0];
              end
            end
            4'h2: begin
              pe_dir_next = merge16(pe_dir_reg, req_reg.wdata, req_reg.be);
            end
            4'h4: begin
              pe_sel1_next = merge16(pe_sel1_reg, req_reg.wdata, req_reg.be);
            end
            4'h8: begin
              pe_sel2_next = merge16(pe_sel2_reg, req_reg.wdata, req_reg.be);
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_state_reg <= BUS_IDLE;
      req_reg <= '0;
      strap_pending_reg <= 1'b1;
      waitrequest_reg <= 1'b1;
      readdata_reg <= 32'h00000000;
      pd_sel_reg <= `PD_SEL_RST;
      pe_dir_reg <= `PE_DIR_RST;
      pe_sel1_reg <= `PE_SEL_RST;
      pe_sel2_reg <= `PE_SEL_RST;
    end else begin
      bus_state_reg <= bus_state_next;
      req_reg <= req_next;
      strap_pending_reg <= strap_pending_next;
      waitrequest_reg <= waitrequest_next;
      readdata_reg <= readdata_next;
      pd_sel_reg <= pd_sel_next;
      pe_dir_reg <= pe_dir_next;
      pe_sel1_reg <= pe_sel1_next;
      pe_sel2_reg <= pe_sel2_next;
    end
  end

  // Pin multiplexer. Every pin-facing signal is registered, which costs one
  // cycle of latency but keeps the pad outputs glitch free.
  always_comb begin
    pin_func_e f;
    pin_drive_s d;
    f = FN_GPIO;
    d = '0;
    // Each port D pin takes both drive and enable from the function that owns it.
    for (int i = 0; i < 7; i++) begin
      if (pd_sel_reg[i]) begin
        pd_out_next[i] = bus_data_out_i[i];
        pd_oe_next[i] = bus_data_oe_i[i];
      end else begin
        pd_out_next[i] = pd_gpio_out_i[i];
        pd_oe_next[i] = pd_gpio_oe_i[i];
      end
    end
    // The pin level reaches only the owning function; the other one sees 0.
    pd_gin_next = pd_pin_i & ~pd_sel_reg;
    bd_in_next = pd_pin_i & pd_sel_reg;

    // Pins 11..0 are treated as port I/O under their direction bits here.
    pe_out_next = pe_gpio_out_i;
    pe_oe_next = pe_dir_reg;
    pe_gin_next = pe_pin_i;
    tmr_in_next = 4'h0;
    // The manual reset input idles high, so a pin in any other function
    // can never pull the device into reset.
    manual_reset_next = 1'b1;
    for (int p = 0; p < 4; p++) begin
      f = decode_pe_func(2'(p), pe_code[p]);
      d.out = pe_gpio_out_i[`PE_MUX_LO + p];
      d.oe = pe_dir_reg[`PE_MUX_LO + p];
      unique case (f)
        FN_GPIO: begin
        end
        // Timer pins keep the direction bit, as the timer may use them either way.
        FN_TIMER: begin
          d.out = timer4_out_i[p];
          tmr_in_next[p] = pe_pin_i[`PE_MUX_LO + p];
        end
        // Pin 15 carries acknowledge 1 and pin 14 acknowledge 0, which is
        // the low bit of the pin index, and is driven out of the pin whatever its direction bit.
        FN_DMA: begin
          d.out = dma_ack_i[p[0]];
          d.oe = 1'b1;
        end
        FN_IRQ: begin
          d.out = irq_out_i;
          d.oe = 1'b1;
        end
        FN_MANUAL_RESET: begin
          d.out = 1'b0;
          d.oe = 1'b0;
          manual_reset_next = pe_pin_i[`PE_MUX_LO + p];
        end
        FN_TXD: begin
          d.out = serial3_txd_i;
          d.oe = 1'b1;
        end
        default: begin
          d.oe = 1'b0;
        end
      endcase
      pe_out_next[`PE_MUX_LO + p] = d.out;
      pe_oe_next[`PE_MUX_LO + p] = d.oe;
      // A pin lent to another function reads 0 as port data, so software
      // polling the port never sees a peripheral's traffic.
      if (f != FN_GPIO) begin
        pe_gin_next[`PE_MUX_LO + p] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pd_out_reg <= 7'h00;
      pd_oe_reg <= 7'h00;
      pd_gin_reg <= 7'h00;
      bd_in_reg <= 7'h00;
      pe_out_reg <= 16'h0000;
      pe_oe_reg <= 16'h0000;
      pe_gin_reg <= 16'h0000;
      tmr_in_reg <= 4'h0;
      manual_reset_reg <= 1'b1;
    end else begin
      pd_out_reg <= pd_out_next;
      pd_oe_reg <= pd_oe_next;
      pd_gin_reg <= pd_gin_next;
      bd_in_reg <= bd_in_next;
      pe_out_reg <= pe_out_next;
      pe_oe_reg <= pe_oe_next;
      pe_gin_reg <= pe_gin_next;
      tmr_in_reg <= tmr_in_next;
      manual_reset_reg <= manual_reset_next;
    end
  end

  assign avs_readdata_o = readdata_reg;
  assign avs_waitrequest_o = waitrequest_reg;
  assign pd_pin_o = pd_out_reg;
  assign pd_pin_oe_o = pd_oe_reg;
  assign pd_gpio_in_o = pd_gin_reg;
  assign bus_data_in_o = bd_in_reg;
  assign pe_pin_o = pe_out_reg;
  assign pe_pin_oe_o = pe_oe_reg;
  assign pe_gpio_in_o = pe_gin_reg;
  assign timer4_in_o = tmr_in_reg;
  assign manual_reset_in_o = manual_reset_reg;

endmodule : pin_function_select

//--- pin_partner.sv
`timescale 1ns/1ps
module pin_partner (
  input wire logic [6:0] pd_out_i,
  input wire logic [6:0] pd_oe_i,
  input wire logic [6:0] ext_d_i,
  input wire logic [15:0] pe_out_i,
  input wire logic [15:0] pe_oe_i,
  input wire logic [15:0] ext_e_i,
  output logic [6:0] pd_level_o,
  output logic [15:0] pe_level_o
);
  // Undriven pins carry an external device's known level rather than a stale echo.
  assign pd_level_o = (pd_oe_i & pd_out_i) | (~pd_oe_i & ext_d_i);
  assign pe_level_o = (pe_oe_i & pe_out_i) | (~pe_oe_i & ext_e_i);
endmodule : pin_partner

//--- pin_function_select_properties.sv
`timescale 1ns/1ps
module pin_function_select_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [6:0] pd_pin_oe_o,
  input wire logic [6:0] pd_gpio_oe_i,
  input wire logic [6:0] bus_data_oe_i,
  input wire logic [6:0] pd_gpio_in_o,
  input wire logic [6:0] bus_data_in_o,
  input wire logic [15:0] pe_pin_i,
  input wire logic [15:0] pe_pin_o,
  input wire logic [15:0] pe_pin_oe_o,
  input wire logic [15:0] pe_gpio_out_i,
  input wire logic [15:0] pe_gpio_in_o,
  input wire logic [3:0] timer4_in_o,
  input wire logic manual_reset_in_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer lasted more than one cycle");
  a_ack_has_req: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
    else $error("answer without request");
  a_idle_data_zero: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0)
    else $error("read data outside answer");
  a_upper_half_zero: assert property (avs_readdata_o[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_pd_in_split: assert property ((pd_gpio_in_o & bus_data_in_o) == 7'h00)
    else $error("port D level routed to both functions");
  a_pd_oe_source: assert property ((pd_pin_oe_o & ~$past(pd_gpio_oe_i | bus_data_oe_i)) == 7'h00)
    else $error("port D driven without a source enable");
  a_low_pins_out: assert property (((pe_pin_o[11:0] ^ $past(pe_gpio_out_i[11:0]))
    & pe_pin_oe_o[11:0]) == 12'h000)
    else $error("port E low pin value not port data");
  a_low_pins_in: assert property (!$past(rst_i) |-> pe_gpio_in_o[11:0] == $past(pe_pin_i[11:0]))
    else $error("port E low pin input not routed");
  a_manual_reset_undriven: assert property (!manual_reset_in_o |-> !pe_pin_oe_o[13])
    else $error("manual reset pin driven");
  a_timer_in_level: assert property ((timer4_in_o & ~$past(pe_pin_i[15:12])) == 4'h0)
    else $error("timer input not pin level");
  c_write: cover property (!avs_waitrequest_o && avs_write_i);
  c_manual_reset: cover property (!manual_reset_in_o);
  c_bus_data: cover property (bus_data_in_o != 7'h00);
  c_timer: cover property (timer4_in_o != 4'h0);
endmodule : pin_function_select_properties

bind pin_function_select pin_function_select_properties u_props (.clk_i, .rst_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .pd_pin_oe_o, .pd_gpio_oe_i, .bus_data_oe_i,
  .pd_gpio_in_o, .bus_data_in_o, .pe_pin_i, .pe_pin_o, .pe_pin_oe_o, .pe_gpio_out_i, .pe_gpio_in_o,
  .timer4_in_o, .manual_reset_in_o);

//--- tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0, rst_i = 1'b1, ext_rom_disabled_mode_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'h0;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0, avs_waitrequest_o;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
  logic [6:0] pd_pin_i, pd_pin_o, pd_pin_oe_o, pd_gpio_in_o, bus_data_in_o;
  logic [6:0] pd_gpio_out_i = 7'h3C, pd_gpio_oe_i = 7'h55, ext_d = 7'h2A;
  logic [6:0] bus_data_out_i = 7'h43, bus_data_oe_i = 7'h7F;
  logic [15:0] pe_pin_i, pe_pin_o, pe_pin_oe_o, pe_gpio_in_o;
  logic [15:0] pe_gpio_out_i = 16'h5C3A, ext_e = 16'h85A5;
  logic [3:0] timer4_out_i = 4'hA, timer4_in_o;
  logic [1:0] dma_ack_i = 2'h1;
  logic irq_out_i = 1'b1, serial3_txd_i = 1'b0, manual_reset_in_o;
  int num_errors = 0, tests_run = 0;
  always #2 clk_i = ~clk_i;
  pin_function_select DUT (.clk_i, .rst_i, .ext_rom_disabled_mode_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .pd_pin_i, .pd_pin_o, .pd_pin_oe_o, .pd_gpio_out_i, .pd_gpio_oe_i, .pd_gpio_in_o,
    .bus_data_out_i, .bus_data_oe_i, .bus_data_in_o, .pe_pin_i, .pe_pin_o, .pe_pin_oe_o,
    .pe_gpio_out_i, .pe_gpio_in_o, .timer4_out_i, .timer4_in_o, .dma_ack_i, .irq_out_i,
    .serial3_txd_i, .manual_reset_in_o);
  pin_partner u_pins (.pd_out_i(pd_pin_o), .pd_oe_i(pd_pin_oe_o), .ext_d_i(ext_d),
    .pe_out_i(pe_pin_o), .pe_oe_i(pe_pin_oe_o), .ext_e_i(ext_e), .pd_level_o(pd_pin_i),
    .pe_level_o(pe_pin_i));
  task report_and_stop;
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task bus(input logic w, input logic [3:0] a, input logic [15:0] d, input logic [3:0] b,
           output logic [31:0] q);
    int n;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= {16'h0, d};
    avs_byteenable_i <= b;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (avs_waitrequest_o !== 1'b0) begin
      num_errors++;
      report_and_stop;
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task wreg(input logic [3:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'h3, q);
  endtask : wreg
  task rchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0, 4'h3, q);
    check(q, e);
  endtask : rchk
  task do_reset(input logic m);
    ext_rom_disabled_mode_i <= m;
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : do_reset
  task t_reset_values;
    check(pe_pin_oe_o, 16'h0);
    check(pd_pin_oe_o, pd_gpio_oe_i);
    rchk(4'h0, 32'h0);
    rchk(4'h4, 32'h0);
    rchk(4'h8, 32'h0);
    rchk(4'hC, 32'h0);
  endtask : t_reset_values
  task t_strap;
    do_reset(1'b1);
    rchk(4'h0, 32'h7F);
    check(pd_pin_oe_o, 7'h7F);
    check(pd_pin_o, bus_data_out_i);
    check(bus_data_in_o, bus_data_out_i);
    check(pd_gpio_in_o, 7'h00);
    do_reset(1'b0);
  endtask : t_strap
  task t_pd_mix;
    logic [31:0] q;
    wreg(4'h0, 16'h000F);
    bus(1'b1, 4'h0, 16'h0000, 4'h2, q);
    rchk(4'h0, 32'h0F);
    repeat (4) @(posedge clk_i);
    check(pd_pin_oe_o, 7'h5F);
    check(pd_pin_o & 7'h5F, 7'h13);
    check(pd_gpio_in_o, 7'h30);
    check(bus_data_in_o, 7'h03);
  endtask : t_pd_mix
  task t_dir;
    logic [31:0] q;
    wreg(4'h4, 16'hA5C3);
    rchk(4'h4, 32'hA5C3);
    repeat (4) @(posedge clk_i);
    check(pe_pin_oe_o, 16'hA5C3);
    check(pe_gpio_in_o, (pe_gpio_out_i & 16'hA5C3) | (ext_e & ~16'hA5C3));
    bus(1'b1, 4'h4, 16'hFFFF, 4'h1, q);
    rchk(4'h4, 32'hA5FF);
    bus(1'b1, 4'h6, 16'h1234, 4'h3, q);
    rchk(4'h6, 32'h0);
    rchk(4'h4, 32'hA5FF);
    wreg(4'hC, 16'hFFFF);
    wreg(4'h8, 16'h00FF);
    rchk(4'hC, 32'hFFFF);
    repeat (4) @(posedge clk_i);
    check(pe_pin_oe_o[11:0], 12'h5FF);
  endtask : t_dir
  task t_fields;
    logic [3:0] dv, oe, o, g, lvl;
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < 4; c++) begin
        dv = k ? 4'hF : 4'h0;
        wreg(4'h4, {dv, 12'h000});
        wreg(4'h8, {{4{c[1:0]}}, 8'h00});
        rchk(4'h8, {16'h0, {4{c[1:0]}}, 8'h00});
        repeat (4) @(posedge clk_i);
        case (c)
          0: begin
            g = 4'hF;
            oe = dv;
            o = pe_gpio_out_i[15:12];
          end
          1: begin
            g = 4'h0;
            oe = dv;
            o = timer4_out_i;
          end
          2: begin
            g = 4'h1;
            oe = {2'b11, 1'b0, dv[0]};
            o = {dma_ack_i, 1'b0, pe_gpio_out_i[12]};
          end
          default: begin
            g = 4'h6;
            oe = {1'b1, dv[2:1], 1'b1};
            o = {irq_out_i, pe_gpio_out_i[14:13], serial3_txd_i};
          end
        endcase
        lvl = (oe & o) | (~oe & ext_e[15:12]);
        check(pe_pin_oe_o[15:12], oe);
        check(pe_pin_o[15:12] & oe, o & oe);
        check(pe_gpio_in_o[15:12], lvl & g);
        check(timer4_in_o, (c == 1) ? lvl : 4'h0);
        check(manual_reset_in_o, (c == 2) ? lvl[1] : 1'b1);
      end
    end
  endtask : t_fields
  initial begin
    do_reset(1'b0);
    t_reset_values;
    t_strap;
    t_pd_mix;
    t_dir;
    t_fields;
    report_and_stop;
  end
endmodule : tb
